// ---- rtl/trc_core.sv ----
// transfer request handshake, completion flags and queued-submit entry
// assumes AXI4-Lite master on one side, shared transfer engine on the
// other; engine pulses are one cycle wide and synchronous to MCLK_IN
//
// Contract
// - queued flag at handshake bit 29 shows the list is queued
// - queued flag rises only after one delay slot following submit
// - transfer end flag bit 19 set when whole list finishes
// - end flag also set by finished entry with options bit 28
// - end flag is one sticky bit, no occurrence count
// - submit while queued sets flag bit 17 of flag register
// - set flag with enable makes the core enter its routine
// - three instructions retire before that routine is entered
// - routine address fetched at parameter base plus 0x01C4
// - engine serves processors round robin, completion time varies
// - entry interrupt reaches only the initiating processor
// - queued flag clears only after final entry completes; here a suspend acknowledge also clears it
// - submit request bit at handshake bit 28, one submits list
// - engine clears queued flag on normal or error completion
// - reset clears priority, suspend, queued and submit bits
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module trc_core #(
   parameter int              ID_W    = 2,   // processor id width
   parameter logic [ID_W-1:0] CORE_ID = '0   // this core's id
) (
   input  wire logic            MCLK_IN,          // 25 MHz clock
   input  wire logic            RST_N_IN,         // async reset, low
   input  wire logic [7:0]      AWADDR_IN,        // write address
   input  wire logic            AWVALID_IN,       // write addr valid
   output logic                 AWREADY_OUT,      // write addr ready
   input  wire logic [31:0]     WDATA_IN,         // write data
   input  wire logic [3:0]      WSTRB_IN,         // byte strobes
   input  wire logic            WVALID_IN,        // write data valid
   output logic                 WREADY_OUT,       // write data ready
   output logic [1:0]           BRESP_OUT,        // write response
   output logic                 BVALID_OUT,       // response valid
   input  wire logic            BREADY_IN,        // response ready
   input  wire logic [7:0]      ARADDR_IN,        // read address
   input  wire logic            ARVALID_IN,       // read addr valid
   output logic                 ARREADY_OUT,      // read addr ready
   output logic [31:0]          RDATA_OUT,        // read data
   output logic [1:0]           RRESP_OUT,        // read response
   output logic                 RVALID_OUT,       // read data valid
   input  wire logic            RREADY_IN,        // read data ready
   input  wire logic            ENG_LIST_DONE_IN, // list finished pulse
   input  wire logic            ENG_ENTRY_DONE_IN,// entry finished pulse
   input  wire logic [31:0]     ENG_ENTRY_OPT_IN, // finished entry options
   input  wire logic [ID_W-1:0] ENG_ID_IN,        // owner of done event
   input  wire logic            ENG_SUSP_ACK_IN,  // suspend taken pulse
   input  wire logic            INSTR_RETIRE_IN,  // core retired one
   output logic                 QUEUED_OUT,       // list queued level
   output logic                 PRIO_OUT,         // high priority level
   output logic                 SUSPEND_OUT,      // suspend request
   output logic                 END_IRQ_OUT,      // end flag and enable
   output logic                 INT_TAKE_OUT,     // routine entry pulse
   output logic [31:0]          VEC_ADDR_OUT      // routine slot address
);

   typedef struct packed {
      logic                aw_full;
      logic [7:0]          aw_addr;
      logic                w_full;
      logic [31:0]         w_data;
      logic [3:0]          w_strb;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                rvalid;
      logic [31:0]         rdata;
      logic [1:0]          rresp;
      logic                prio;
      logic                susp;
      logic                queued;
      logic                submit;
      logic                slot;
      logic                end_flag;
      logic                swq_flag;
      logic                end_en;
      logic                swq_en;
      logic [31:0]         pbase;
      trc_pkg::trc_take_t  take;
      logic [1:0]          gap;
      logic [31:0]         vec;
   } trc_state_t;

   trc_state_t s;
   trc_state_t next_s;
   logic       do_wr;
   logic [31:0] wmask;
   logic       mine;
   logic       list_done;
   logic       entry_irq;
   logic       swq_set;
   logic       wr_hs;
   logic       wr_flag;

   // bus ready terms are combinational; one write held at a time
   assign AWREADY_OUT  = ~s.aw_full & ~s.bvalid;
   assign WREADY_OUT   = ~s.w_full & ~s.bvalid;
   assign ARREADY_OUT  = ~s.rvalid;
   assign BVALID_OUT   = s.bvalid;
   assign BRESP_OUT    = s.bresp;
   assign RVALID_OUT   = s.rvalid;
   assign RDATA_OUT    = s.rdata;
   assign RRESP_OUT    = s.rresp;
   assign QUEUED_OUT   = s.queued;
   assign PRIO_OUT     = s.prio;
   assign SUSPEND_OUT  = s.susp;
   assign END_IRQ_OUT  = s.end_flag & s.end_en;
   assign INT_TAKE_OUT = (s.take == trc_pkg::TRC_ENTER);
   assign VEC_ADDR_OUT = s.vec;

   // completion events from the engine; completion may come at any
   // cycle since other processors share the engine in turn
   assign mine      = (ENG_ID_IN == CORE_ID);
   assign list_done = ENG_LIST_DONE_IN & mine;
   assign entry_irq = ENG_ENTRY_DONE_IN & mine
                    & ENG_ENTRY_OPT_IN[trc_pkg::ENTRY_IRQ_BIT];
   assign do_wr     = s.aw_full & s.w_full & ~s.bvalid;
   assign wmask     = {{8{s.w_strb[3]}}, {8{s.w_strb[2]}},
                       {8{s.w_strb[1]}}, {8{s.w_strb[0]}}};
   assign wr_hs     = do_wr & (s.aw_addr == trc_pkg::HS_OFF)
                    & s.w_strb[3];
   assign wr_flag   = do_wr & (s.aw_addr == trc_pkg::FLAG_OFF)
                    & s.w_strb[2];
   assign swq_set   = wr_hs & s.w_data[trc_pkg::SUBMIT_BIT]
                    & s.queued;

   // single next-state process for bus, handshake, flags and entry
   always_comb begin
      next_s = s;
      // bus write channels are taken in either order
      if (AWVALID_IN & AWREADY_OUT) begin
         next_s.aw_full = 1'b1;
         next_s.aw_addr = AWADDR_IN;
      end
      if (WVALID_IN & WREADY_OUT) begin
         next_s.w_full = 1'b1;
         next_s.w_data = WDATA_IN;
         next_s.w_strb = WSTRB_IN;
      end
      if (s.bvalid & BREADY_IN) begin
         next_s.bvalid = 1'b0;
      end
      if (do_wr) begin
         next_s.aw_full = 1'b0;
         next_s.w_full  = 1'b0;
         next_s.bvalid  = 1'b1;
         case (s.aw_addr)
            trc_pkg::HS_OFF, trc_pkg::FLAG_OFF,
            trc_pkg::EN_OFF, trc_pkg::PBASE_OFF:
               next_s.bresp = trc_pkg::RESP_OKAY;
            default: next_s.bresp = trc_pkg::RESP_SLVERR;
         endcase
      end
      // read answers one cycle after the address is taken
      if (ARVALID_IN & ~s.rvalid) begin
         next_s.rvalid = 1'b1;
         next_s.rresp  = trc_pkg::RESP_OKAY;
         next_s.rdata  = '0;
         case (ARADDR_IN)
            trc_pkg::HS_OFF: begin
               next_s.rdata[trc_pkg::PRIO_BIT]   = s.prio;
               next_s.rdata[trc_pkg::SUSP_BIT]   = s.susp;
               next_s.rdata[trc_pkg::QUEUED_BIT] = s.queued;
               next_s.rdata[trc_pkg::SUBMIT_BIT] = s.submit;
            end
            trc_pkg::FLAG_OFF: begin
               next_s.rdata[trc_pkg::END_BIT] = s.end_flag;
               next_s.rdata[trc_pkg::SWQ_BIT] = s.swq_flag;
            end
            trc_pkg::EN_OFF: begin
               next_s.rdata[trc_pkg::END_BIT] = s.end_en;
               next_s.rdata[trc_pkg::SWQ_BIT] = s.swq_en;
            end
            trc_pkg::PBASE_OFF: next_s.rdata = s.pbase;
            default: next_s.rresp = trc_pkg::RESP_SLVERR;
         endcase
      end else if (s.rvalid & RREADY_IN) begin
         next_s.rvalid = 1'b0;
      end
      // submit self-clears unless suspend holds it; the slot stage
      // keeps the queued flag off in the cycle after submission
      next_s.submit = s.submit & s.susp;
      next_s.slot   = s.submit & ~s.susp & ~s.queued;
      if (s.slot) begin
         next_s.queued = 1'b1;
      end
      // the engine's end-of-list event or a suspend acknowledge drops the queued flag,
      // error or not; entry completions leave it alone
      if (list_done) begin
         next_s.queued = 1'b0;
      end
      if (ENG_SUSP_ACK_IN) begin
         next_s.submit = s.queued;
         next_s.queued = 1'b0;
      end
      if (wr_hs) begin
         next_s.prio = s.w_data[trc_pkg::PRIO_BIT];
         next_s.susp = s.w_data[trc_pkg::SUSP_BIT];
         // a submit that finds a list queued is dropped and flagged
         if (s.w_data[trc_pkg::SUBMIT_BIT] & ~s.queued) begin
            next_s.submit = 1'b1;
         end
      end
      if (do_wr & (s.aw_addr == trc_pkg::EN_OFF) & s.w_strb[2]) begin
         next_s.end_en = s.w_data[trc_pkg::END_BIT];
         next_s.swq_en = s.w_data[trc_pkg::SWQ_BIT];
      end
      if (do_wr & (s.aw_addr == trc_pkg::PBASE_OFF)) begin
         next_s.pbase = (s.pbase & ~wmask) | (s.w_data & wmask);
      end
      // write one to clear, then events set: set wins the tie
      if (wr_flag & s.w_data[trc_pkg::END_BIT]) begin
         next_s.end_flag = 1'b0;
      end
      if (wr_flag & s.w_data[trc_pkg::SWQ_BIT]) begin
         next_s.swq_flag = 1'b0;
      end
      // one bit only: many completions read as one
      if (list_done | entry_irq) begin
         next_s.end_flag = 1'b1;
      end
      if (swq_set) begin
         next_s.swq_flag = 1'b1;
      end
      // routine entry waits for three retired instructions
      case (s.take)
         trc_pkg::TRC_IDLE: begin
            if (swq_set & s.swq_en) begin
               next_s.take = trc_pkg::TRC_WAIT;
               next_s.gap  = '0;
            end
         end
         trc_pkg::TRC_WAIT: begin
            if (INSTR_RETIRE_IN) begin
               next_s.gap = s.gap + 2'h1;
               if (s.gap == trc_pkg::INSTR_GAP - 2'h1) begin
                  next_s.take = trc_pkg::TRC_ENTER;
                  next_s.vec  = s.pbase + trc_pkg::SWQ_VEC_OFF;
               end
            end
         end
         trc_pkg::TRC_ENTER: next_s.take = trc_pkg::TRC_IDLE;
         default: next_s.take = trc_pkg::TRC_IDLE;
      endcase
   end

   // state register; reset drops every handshake bit
   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         s       <= '0;
         s.pbase <= trc_pkg::PBASE_RST;
         s.take  <= trc_pkg::TRC_IDLE;
      end else begin
         s <= next_s;
      end
   end

   // checks on the handshake and flag behaviour
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!RST_N_IN);

   q_slot_a: assert property ($rose(s.queued) |-> $past(s.slot,1)
                              && $past(s.submit,2))
      else $error("queued flag rose without a delay slot");
   q_early_a: assert property (s.submit && !s.queued && !s.susp
                               |=> !s.queued ##1 s.queued)
      else $error("queued flag timing after submit is wrong");
   q_clear_a: assert property (list_done && !ENG_SUSP_ACK_IN
                               |=> !s.queued)
      else $error("queued flag stayed set after list end");
   q_hold_a: assert property (s.queued && !list_done && !ENG_SUSP_ACK_IN
                              |=> s.queued)
      else $error("queued flag dropped before list end");
   end_set_a: assert property (list_done || entry_irq
                               |=> s.end_flag)
      else $error("end flag not set on completion");
   end_entry_a: assert property (ENG_ENTRY_DONE_IN && !mine
                  && !list_done && !s.end_flag && !wr_flag
                  |=> !s.end_flag)
      else $error("end flag set by a foreign entry");
   flag_sticky_a: assert property (s.end_flag && !wr_flag
                                   |=> s.end_flag)
      else $error("end flag lost without a clear");
   swq_set_a: assert property (wr_hs && s.w_data[trc_pkg::SUBMIT_BIT]
                   && s.queued |=> s.swq_flag && !s.submit)
      else $error("submit while queued not flagged");
   take_gap_a: assert property (s.take == trc_pkg::TRC_WAIT
                   && INSTR_RETIRE_IN && s.gap == 2'h2
                   |=> INT_TAKE_OUT)
      else $error("routine not entered after third instruction");
   take_vec_a: assert property (INT_TAKE_OUT |-> VEC_ADDR_OUT ==
                   $past(s.pbase) + trc_pkg::SWQ_VEC_OFF)
      else $error("routine slot address wrong");

   submit_c: cover property (s.slot ##1 s.queued ##[1:50] !s.queued);
   swq_take_c: cover property (swq_set ##[3:40] INT_TAKE_OUT);
   entry_c: cover property (entry_irq ##1 s.end_flag);
   tie_c: cover property (wr_flag && list_done);

endmodule : trc_core
`default_nettype wire

// ---- rtl/trc_pkg.sv ----
// constants for the transfer request and completion handshake block
// assumes a 32-bit AXI4-Lite register bus with byte addressed words
package trc_pkg;
   // register byte offsets
   localparam logic [7:0] HS_OFF    = 8'h00; // handshake register
   localparam logic [7:0] FLAG_OFF  = 8'h04; // interrupt flag register
   localparam logic [7:0] EN_OFF    = 8'h08; // interrupt enable register
   localparam logic [7:0] PBASE_OFF = 8'h0C; // parameter memory base
   // handshake register fields
   localparam int PRIO_BIT   = 31;
   localparam int SUSP_BIT   = 30;
   localparam int QUEUED_BIT = 29;
   localparam int SUBMIT_BIT = 28;
   // flag and enable register fields
   localparam int END_BIT    = 19;
   localparam int SWQ_BIT    = 17;
   // options field of a finished entry
   localparam int ENTRY_IRQ_BIT = 28;
   // vector slot of the submit-while-queued routine
   localparam logic [31:0] SWQ_VEC_OFF = 32'h0000_01C4;
   // instructions retired before the routine is entered
   localparam logic [1:0] INSTR_GAP = 2'h3;
   // reset values
   localparam logic [31:0] PBASE_RST = 32'h0000_0000;
   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // interrupt entry sequencer
   typedef enum logic [1:0] {TRC_IDLE, TRC_WAIT, TRC_ENTER} trc_take_t;
endpackage : trc_pkg

// ---- verif/trc_eng_model.sv ----
// behavioural model of the shared transfer engine seen by one core
// assumes a single clock; the bench picks service delay and entry mode
`timescale 1ns/10ps
`default_nettype none
module trc_eng_model #(
   parameter logic [1:0] OWN_ID = 2'h0   // id of the served core
) (
   input  wire logic        clk_in,        // core clock
   input  wire logic        rst_n_in,      // async reset, low
   input  wire logic        queued_in,     // core list is queued
   input  wire logic [1:0]  mode_in,       // 0 own irq, 1 foreign, 2 none
   input  wire logic [7:0]  delay_in,      // cycles per serviced entry
   output logic             list_done_out, // whole list finished
   output logic             entry_done_out,// one entry finished
   output logic [31:0]      opt_out,       // options of that entry
   output logic [1:0]       id_out         // owner of the event
);
   logic [8:0] cnt;
   logic       fin;
   // idle lines toggle so a stale value is never mistaken for a real one
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt            <= 9'h000;
         fin            <= 1'b0;
         list_done_out  <= 1'b0;
         entry_done_out <= 1'b0;
         opt_out        <= 32'h0000_0000;
         id_out         <= 2'h0;
      end else begin
         list_done_out  <= 1'b0;
         entry_done_out <= 1'b0;
         opt_out        <= ~opt_out;
         id_out         <= id_out + 2'h1;
         if (!queued_in) begin
            cnt <= 9'h000;
            fin <= 1'b0;
         end else if (!fin) begin
            cnt <= cnt + 9'h001;
            if (cnt == {1'b0, delay_in}) begin
               entry_done_out <= 1'b1;
               opt_out <= (mode_in != 2'h2) ? 32'h1000_0000 : 32'h0;
               id_out  <= (mode_in == 2'h1) ? OWN_ID + 2'h1 : OWN_ID;
            end
            if (cnt == {delay_in, 1'b0}) begin
               list_done_out <= 1'b1;
               id_out        <= OWN_ID;
               fin           <= 1'b1;
            end
         end
      end
   end
endmodule : trc_eng_model
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench for trc_core against the engine model
// assumes one bus master and the core's one-cycle register answers
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic        clk, rst_n, awv, wv, brdy, arv, rrdy, ret;
   logic        awr, wrr, bv, arr, rv, qd, ld, ed, take, endi, prio, susp;
   logic [7:0]  awa, ara, dly;
   logic [31:0] wd, pb, rdd, opt, vec;
   logic [3:0]  ws;
   logic [1:0]  mode, br, rr, eid;
   logic [33:0] q[$];
   int          err_count, n_compared;

   trc_core i_trc_core (.MCLK_IN(clk), .RST_N_IN(rst_n), .AWADDR_IN(awa),
      .AWVALID_IN(awv), .AWREADY_OUT(awr), .WDATA_IN(wd), .WSTRB_IN(ws),
      .WVALID_IN(wv), .WREADY_OUT(wrr), .BRESP_OUT(br), .BVALID_OUT(bv),
      .BREADY_IN(brdy), .ARADDR_IN(ara), .ARVALID_IN(arv),
      .ARREADY_OUT(arr), .RDATA_OUT(rdd), .RRESP_OUT(rr), .RVALID_OUT(rv),
      .RREADY_IN(rrdy), .ENG_LIST_DONE_IN(ld), .ENG_ENTRY_DONE_IN(ed),
      .ENG_ENTRY_OPT_IN(opt), .ENG_ID_IN(eid), .ENG_SUSP_ACK_IN(1'b0),
      .INSTR_RETIRE_IN(ret), .QUEUED_OUT(qd), .PRIO_OUT(prio),
      .SUSPEND_OUT(susp), .END_IRQ_OUT(endi), .INT_TAKE_OUT(take),
      .VEC_ADDR_OUT(vec));
   trc_eng_model i_trc_eng_model (.clk_in(clk), .rst_n_in(rst_n),
      .queued_in(qd), .mode_in(mode), .delay_in(dly), .list_done_out(ld),
      .entry_done_out(ed), .opt_out(opt), .id_out(eid));

   always #20 clk = ~clk;

   task automatic chk(input logic [33:0] s, input logic [33:0] e);
      n_compared++;
      if (s !== e) begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, s, e);
      end
   endtask : chk

   function automatic logic [33:0] pop();
      return (q.size() != 0) ? q.pop_front() : 34'hX;
   endfunction : pop

   // results are matched to the oldest note as they appear
   always @(posedge clk) begin
      if (bv && brdy) chk({br, 32'h0}, pop());
      if (rv && rrdy) chk({rr, rdd}, pop());
      if (take) chk({2'h0, vec}, pop());
   end

   // bus master: each valid and its payload hold until their own ready
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] r);
      logic ta, tw, da, dw, tb;
      da = 1'b0;
      dw = 1'b0;
      q.push_back({r, 32'h0});
      awa <= a;
      wd  <= d;
      ws  <= s;
      awv <= 1'b1;
      wv  <= 1'b1;
      while (!(da && dw)) begin
         @(negedge clk);
         ta = awr && awv;
         tw = wrr && wv;
         @(posedge clk);
         if (ta) begin
            awv <= 1'b0;
            da = 1'b1;
         end
         if (tw) begin
            wv <= 1'b0;
            dw = 1'b1;
         end
      end
      brdy <= 1'b1;
      do begin
         @(negedge clk);
         tb = bv;
         @(posedge clk);
      end while (!tb);
      brdy <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [1:0] r,
                     input logic [31:0] d);
      logic ta, tb;
      q.push_back({r, d});
      ara <= a;
      arv <= 1'b1;
      do begin
         @(negedge clk);
         ta = arr;
         @(posedge clk);
      end while (!ta);
      arv  <= 1'b0;
      rrdy <= 1'b1;
      do begin
         @(negedge clk);
         tb = rv;
         @(posedge clk);
      end while (!tb);
      rrdy <= 1'b0;
   endtask : rd

   // one retired instruction every second cycle, changed on the edge
   task automatic retire(input int n);
      repeat (n) begin
         ret <= 1'b1;
         @(posedge clk);
         ret <= 1'b0;
         @(posedge clk);
      end
   endtask : retire

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   // watchdog well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      finish_test();
   end

   initial begin
      clk        = 1'b0;
      rst_n      = 1'b0;
      awv        = 1'b0;
      wv         = 1'b0;
      brdy       = 1'b0;
      arv        = 1'b0;
      rrdy       = 1'b0;
      ret        = 1'b0;
      awa        = 8'h00;
      ara        = 8'h00;
      wd         = 32'h0000_0000;
      ws         = 4'h0;
      dly        = 8'h50;
      mode       = 2'h2;
      err_count  = 0;
      n_compared = 0;
      void'($urandom(40));
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // every register reads zero after reset, unmapped is refused
      for (int i = 0; i < 4; i++) begin
         rd(8'(4 * i), trc_pkg::RESP_OKAY, 32'h0000_0000);
      end
      rd(8'h10, trc_pkg::RESP_SLVERR, 32'h0000_0000);
      $display("reset test done");
      pb = $urandom;
      wr(trc_pkg::EN_OFF, 32'h000A_0000, 4'h4, trc_pkg::RESP_OKAY);
      rd(trc_pkg::EN_OFF, trc_pkg::RESP_OKAY, 32'h000A_0000);
      wr(trc_pkg::PBASE_OFF, pb, 4'hF, trc_pkg::RESP_OKAY);
      rd(trc_pkg::PBASE_OFF, trc_pkg::RESP_OKAY, pb);
      wr(8'h10, pb, 4'hF, trc_pkg::RESP_SLVERR);
      $display("register test done");
      // long service so the second submit finds the list still queued
      wr(trc_pkg::HS_OFF, 32'h9000_0000, 4'h8, trc_pkg::RESP_OKAY);
      @(negedge clk);
      chk(34'(qd), 34'h0);
      @(negedge clk);
      chk(34'(qd), 34'h1);
      chk(34'(prio), 34'h1);
      @(posedge clk);
      rd(trc_pkg::HS_OFF, trc_pkg::RESP_OKAY, 32'hA000_0000);
      wr(trc_pkg::HS_OFF, 32'h9000_0000, 4'h8, trc_pkg::RESP_OKAY);
      // noted after the write answer so the notes stay in order
      q.push_back({2'h0, pb + trc_pkg::SWQ_VEC_OFF});
      retire(2);
      repeat (4) begin
         @(negedge clk);
         chk(34'(take), 34'h0);
      end
      @(posedge clk);
      retire(1);
      repeat (3) @(posedge clk);
      chk(34'(q.size()), 34'h0);
      rd(trc_pkg::FLAG_OFF, trc_pkg::RESP_OKAY, 32'h0002_0000);
      // routine: wait for the old list, resubmit, then clear its flag
      do @(negedge clk); while (qd !== 1'b0);
      @(posedge clk);
      wr(trc_pkg::HS_OFF, 32'h1000_0000, 4'h8, trc_pkg::RESP_OKAY);
      @(posedge clk);
      wr(trc_pkg::FLAG_OFF, 32'h0002_0000, 4'h4, trc_pkg::RESP_OKAY);
      rd(trc_pkg::FLAG_OFF, trc_pkg::RESP_OKAY, 32'h0008_0000);
      do @(negedge clk); while (qd !== 1'b0);
      @(posedge clk);
      wr(trc_pkg::FLAG_OFF, 32'h0008_0000, 4'h4, trc_pkg::RESP_OKAY);
      $display("queued submit test done");
      // own flagged entry, foreign flagged entry, unflagged entry
      for (int m = 0; m < 3; m++) begin
         mode <= 2'(m);
         dly  <= 8'(4 + $urandom_range(7, 0));
         wr(trc_pkg::HS_OFF, 32'h1000_0000, 4'h8, trc_pkg::RESP_OKAY);
         do @(negedge clk); while (ed !== 1'b1);
         @(negedge clk);
         chk(34'(endi), 34'(m == 0));
         chk(34'(qd), 34'h1);
         do @(negedge clk); while (ld !== 1'b1);
         @(negedge clk);
         chk(34'(qd), 34'h0);
         chk(34'(endi), 34'h1);
         @(posedge clk);
         rd(trc_pkg::FLAG_OFF, trc_pkg::RESP_OKAY, 32'h0008_0000);
         wr(trc_pkg::FLAG_OFF, 32'h0008_0000, 4'h4, trc_pkg::RESP_OKAY);
      end
      rd(trc_pkg::FLAG_OFF, trc_pkg::RESP_OKAY, 32'h0000_0000);
      $display("completion test done");
      // reset in mid-run with priority, suspend and queued all set
      dly <= 8'hF0;
      wr(trc_pkg::HS_OFF, 32'h9000_0000, 4'h8, trc_pkg::RESP_OKAY);
      @(posedge clk);
      wr(trc_pkg::HS_OFF, 32'hC000_0000, 4'h8, trc_pkg::RESP_OKAY);
      rd(trc_pkg::HS_OFF, trc_pkg::RESP_OKAY, 32'hE000_0000);
      chk(34'({prio, susp}), 34'h3);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk(34'({qd, prio, susp}), 34'h0);
      @(posedge clk);
      rd(trc_pkg::HS_OFF, trc_pkg::RESP_OKAY, 32'h0000_0000);
      rd(trc_pkg::FLAG_OFF, trc_pkg::RESP_OKAY, 32'h0000_0000);
      $display("mid-run reset test done");
      finish_test();
   end
endmodule : testbench
`default_nettype wire
